// ---- verilog/pmv_regs.svh ----
// register offsets, field positions, reset values and timing constants
`ifndef PMV_REGS_SVH
`define PMV_REGS_SVH

`define PMV_REG_ENABLE 3'h0
`define PMV_REG_STATUS 3'h1
`define PMV_REG_BUCK 3'h2
`define PMV_REG_LDO_A 3'h3
`define PMV_REG_LDO_B 3'h4

`define PMV_ENABLE_POR 8'h20
`define PMV_ENABLE_DEFAULT 8'h27
`define PMV_ENABLE_MASK 8'h37
`define PMV_CODE_POR 8'h00

`define PMV_ST_INT_EN 6
`define PMV_ST_UV_FLAG 5
`define PMV_ST_OT_FLAG 4

`define PMV_BUCK_BASE_MV 12'h320
`define PMV_BUCK_FINE_MV 12'h019
`define PMV_BUCK_KNEE_MV 12'h4b0
`define PMV_BUCK_KNEE_CODE 8'h10
`define PMV_BUCK_MAX_CODE 8'h1c
`define PMV_LDO_STEP_MV 12'h032
`define PMV_LDO_ENTRIES 51
`define PMV_LDO_TABLE '{8'h00, 8'h0b, 8'h14, 8'h1d, 8'h25, 8'h2e, 8'h37, 8'h3e, 8'h45, \
    8'h4c, 8'h52, 8'h57, 8'h5c, 8'h61, 8'h65, 8'h69, 8'h6d, 8'h72, 8'h79, 8'h7f, 8'h85, \
    8'h8b, 8'h91, 8'h96, 8'h9a, 8'h9f, 8'ha4, 8'ha8, 8'hac, 8'hb0, 8'hb4, 8'hb7, 8'hba, \
    8'hbd, 8'hc1, 8'hc4, 8'hc7, 8'hc9, 8'hcc, 8'hce, 8'hd1, 8'hd3, 8'hd6, 8'hd8, 8'hda, \
    8'hdc, 8'hde, 8'he1, 8'he3, 8'he6, 8'he8}

// fastest host clock period that the link is built for, in ns
`define PMV_SCL_MIN_PERIOD_NS 2500

`endif

// ---- verilog/pmv_pkg.sv ----
// shared types of the voltage code register block
package pmv_pkg;
    typedef logic [11:0] pmv_mv_type;
    typedef enum logic [3:0] {
        LS_IDLE, LS_ADDR, LS_ACK_ADDR, LS_REG, LS_ACK_REG,
        LS_WDATA, LS_ACK_DATA, LS_RDATA, LS_RACK
    } pmv_link_state_type;
endpackage : pmv_pkg

// ---- verilog/pmv_link_if.sv ----
// toggle handshake carrier between the serial link and the register core
`timescale 1ns/100ps
`default_nettype none
interface pmv_link_if;
    logic wr_tog;
    logic [7:0] wr_data;
    logic [2:0] reg_addr;
    logic rd_tog;
    logic rd_ack_tog;
    logic [7:0] rd_data;
    modport link (output wr_tog, wr_data, reg_addr, rd_tog, input rd_ack_tog, rd_data);
    modport core (input wr_tog, wr_data, reg_addr, rd_tog, output rd_ack_tog, rd_data);
endinterface : pmv_link_if
`default_nettype wire

// ---- verilog/pmv_i2c_link.sv ----
// serial slave running on the host clock pin
`timescale 1ns/100ps
`default_nettype none
module pmv_i2c_link
    import pmv_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h2c // arbitrary value
) (
    input wire logic scl, // host serial clock, link domain
    input wire logic reset, // async, active high
    input wire logic sda_in, // data pin level
    output logic sda_out, // data pin drive value
    output logic sda_oe, // high while pulling data low
    pmv_link_if.link lk // handshake to the core
);
    if (DEV_ADDR[6:3] == 4'h0 || DEV_ADDR[6:3] == 4'hf) begin : g_bad_addr
        $error("device address lies in a reserved group");
    end

    pmv_link_state_type state_r;
    logic start_tog_r, start_seen_r, rw_r;
    logic [2:0] cnt_r;
    logic [7:0] sr_r, tx_r;
    logic ack_s1_r, ack_s2_r;

    // start: data falls while clock is high; counted as a toggle since no edge follows it
    always_ff @(negedge sda_in or posedge reset) begin
        if (reset) start_tog_r <= 1'b0;
        else if (scl) start_tog_r <= ~start_tog_r;
    end

    wire start_now = start_tog_r ^ start_seen_r;
    wire byte_done = cnt_r == 3'h7;
    wire [7:0] sr_nxt = {sr_r[6:0], sda_in};
    wire addr_match = sr_r[7:1] == DEV_ADDR;
    wire rd_ready = ack_s2_r == lk.rd_tog;
    wire [7:0] tx_load = rd_ready ? lk.rd_data : 8'hff; // stale answer reads all ones
    wire drive_low = (state_r == LS_ACK_ADDR && addr_match) || state_r == LS_ACK_REG
        || state_r == LS_ACK_DATA || (state_r == LS_RDATA && !tx_r[7]);

    // read answer toggle crosses in through two flops
    always_ff @(posedge scl or posedge reset) begin
        if (reset) {ack_s2_r, ack_s1_r} <= 2'b00;
        else {ack_s2_r, ack_s1_r} <= {ack_s1_r, lk.rd_ack_tog};
    end

    // bit engine, sampled on the rising clock edge
    always_ff @(posedge scl or posedge reset) begin
        if (reset) begin
            state_r <= LS_IDLE;
            start_seen_r <= 1'b0;
            cnt_r <= 3'h0;
            sr_r <= 8'h00;
            tx_r <= 8'hff;
            rw_r <= 1'b0;
            lk.wr_tog <= 1'b0;
            lk.rd_tog <= 1'b0;
            lk.wr_data <= 8'h00;
            lk.reg_addr <= 3'h0;
        end else if (start_now) begin // repeated start restarts here too
            start_seen_r <= start_tog_r;
            state_r <= LS_ADDR;
            sr_r <= {7'h00, sda_in};
            cnt_r <= 3'h1;
        end else begin
            case (state_r)
                LS_ADDR, LS_REG, LS_WDATA: begin
                    sr_r <= sr_nxt;
                    cnt_r <= cnt_r + 3'h1;
                    if (byte_done) begin
                        state_r <= state_r == LS_ADDR ? LS_ACK_ADDR :
                            state_r == LS_REG ? LS_ACK_REG : LS_ACK_DATA;
                    end
                end
                LS_ACK_ADDR: begin // foreign address: stay silent
                    rw_r <= sr_r[0];
                    cnt_r <= 3'h0;
                    tx_r <= tx_load;
                    state_r <= !addr_match ? LS_IDLE : sr_r[0] ? LS_RDATA : LS_REG;
                end
                LS_ACK_REG: begin
                    lk.reg_addr <= sr_r[2:0]; // low three bits only
                    lk.rd_tog <= ~lk.rd_tog; // prefetch for a later read
                    state_r <= LS_WDATA;
                end
                LS_ACK_DATA: begin
                    lk.wr_data <= sr_r;
                    lk.wr_tog <= ~lk.wr_tog;
                    state_r <= LS_WDATA;
                end
                LS_RDATA: begin
                    tx_r <= {tx_r[6:0], 1'b1};
                    cnt_r <= cnt_r + 3'h1;
                    if (byte_done) state_r <= LS_RACK;
                end
                LS_RACK: begin // host ack asks for the same register again
                    tx_r <= tx_load;
                    state_r <= sda_in ? LS_IDLE : LS_RDATA;
                end
                default: state_r <= LS_IDLE;
            endcase
        end
    end

    // pin drive changes only while the clock is low
    always_ff @(negedge scl or posedge reset) begin
        if (reset) begin
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            sda_oe <= drive_low;
            sda_out <= 1'b0;
        end
    end

    a_nak_foreign: assert property (@(posedge scl) disable iff (reset)
        (state_r == LS_ACK_ADDR && !addr_match) |-> !sda_oe)
        else $error("foreign address was acknowledged");
    a_reg_ack_drive: assert property (@(posedge scl) disable iff (reset)
        (state_r == LS_ACK_REG) |-> sda_oe)
        else $error("register byte not acknowledged");
    c_link_read: cover property (@(posedge scl) disable iff (reset)
        state_r == LS_RACK);
endmodule : pmv_i2c_link
`default_nettype wire

// ---- verilog/pmv_top.sv ----
// voltage code registers, enable edge logic and fault interrupt of the power manager
`timescale 1ns/100ps
`default_nettype none
`include "pmv_regs.svh"

module pmv_top
    import pmv_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h2c // arbitrary value
) (
    input wire logic clock, // core clock, 25 MHz
    input wire logic reset, // async, active high
    input wire logic scl, // host serial clock pin
    input wire logic sda_in, // serial data pin level
    output logic sda_out, // serial data drive value
    output logic sda_oe, // high while pulling data low
    input wire logic enable_pin, // startup enable pin
    input wire logic input_undervoltage_flag, // input undervoltage detector
    input wire logic thermal_shutdown_flag, // thermal shutdown detector
    input wire logic [2:0] rail_valid, // output good: ldo b, ldo a, buck
    output logic fault_irq_n_out, // interrupt pin drive value
    output logic fault_irq_n_oe, // high while pulling interrupt low
    output logic [2:0] rail_enable, // supply enables: ldo b, ldo a, buck
    output logic seq_disable, // 1 = sequencing off
    output logic fault_restart, // 1 = restore power after fault
    output pmv_mv_type buck_mv, // buck target, millivolts
    output pmv_mv_type ldo_a_mv, // first regulator target, millivolts
    output pmv_mv_type ldo_b_mv // second regulator target, millivolts
);
    localparam logic [7:0] LDO_TABLE [`PMV_LDO_ENTRIES] = `PMV_LDO_TABLE;

    pmv_link_if lk ();

    pmv_i2c_link #(
        .DEV_ADDR(DEV_ADDR)
    ) u_link (
        .scl(scl),
        .reset(reset),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .lk(lk)
    );

    // buck: fine steps below the knee, coarse steps up to the top code
    function automatic pmv_mv_type buck_to_mv(input logic [7:0] code);
        pmv_mv_type mv;
        mv = 12'h000;
        if (code < `PMV_BUCK_KNEE_CODE) begin
            mv = `PMV_BUCK_BASE_MV + 12'(code * `PMV_BUCK_FINE_MV);
        end else if (code <= `PMV_BUCK_MAX_CODE) begin
            mv = `PMV_BUCK_KNEE_MV + 12'((code - `PMV_BUCK_KNEE_CODE) * `PMV_LDO_STEP_MV);
        end
        return mv;
    endfunction : buck_to_mv

    // regulator table position gives the step count; unlisted codes read as zero volts
    function automatic pmv_mv_type ldo_to_mv(input logic [7:0] code);
        pmv_mv_type mv;
        mv = 12'h000;
        for (int i = 0; i < `PMV_LDO_ENTRIES; i++) begin
            if (code == LDO_TABLE[i]) begin
                mv = `PMV_BUCK_BASE_MV + 12'(i * `PMV_LDO_STEP_MV);
            end
        end
        return mv;
    endfunction : ldo_to_mv

    // pins and link toggles: s1 feeds only s2, s3 is the edge reference
    logic [7:0] in_s1_r, in_s2_r, in_s3_r;
    wire [7:0] in_raw = {lk.wr_tog, lk.rd_tog, rail_valid, thermal_shutdown_flag,
        input_undervoltage_flag, enable_pin};

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            in_s1_r <= 8'h00;
            in_s2_r <= 8'h00;
            in_s3_r <= 8'h00;
        end else begin
            in_s1_r <= in_raw;
            in_s2_r <= in_s1_r;
            in_s3_r <= in_s2_r;
        end
    end

    // event decode
    wire wr_evt = in_s2_r[7] ^ in_s3_r[7];
    wire rd_evt = in_s2_r[6] ^ in_s3_r[6];
    wire [2:0] valid_live = in_s2_r[5:3];
    wire ot_live = in_s2_r[2];
    wire uv_live = in_s2_r[1];
    wire en_rise = in_s2_r[0] && !in_s3_r[0]; // only the rising edge matters
    wire wr_enable = wr_evt && lk.reg_addr == `PMV_REG_ENABLE;
    wire wr_status = wr_evt && lk.reg_addr == `PMV_REG_STATUS;
    wire wr_buck = wr_evt && lk.reg_addr == `PMV_REG_BUCK;
    wire wr_ldo_a = wr_evt && lk.reg_addr == `PMV_REG_LDO_A;
    wire wr_ldo_b = wr_evt && lk.reg_addr == `PMV_REG_LDO_B;

    logic [7:0] enable_r, buck_code_r, ldo_a_code_r, ldo_b_code_r, rd_data_r;
    logic int_en_r, uv_hold_r, ot_hold_r, rd_ack_tog_r;

    // next values: a rising edge of the pin beats a simultaneous software write
    wire [7:0] enable_nxt = en_rise ? `PMV_ENABLE_DEFAULT :
        wr_enable ? (lk.wr_data & `PMV_ENABLE_MASK) : enable_r;
    wire int_en_nxt = wr_status ? lk.wr_data[`PMV_ST_INT_EN] : int_en_r;
    // echo clear of a sticky flag loses to a fault still present
    wire uv_hold_nxt = uv_live || (uv_hold_r && !(wr_status && lk.wr_data[`PMV_ST_UV_FLAG]));
    wire ot_hold_nxt = ot_live || (ot_hold_r && !(wr_status && lk.wr_data[`PMV_ST_OT_FLAG]));
    wire [7:0] status_view = {1'b0, int_en_r, uv_hold_r, ot_hold_r, 1'b0, valid_live};

    // read mux; addresses 5 to 7 hold nothing and read zero
    wire [7:0] rd_mux = lk.reg_addr == `PMV_REG_ENABLE ? enable_r :
        lk.reg_addr == `PMV_REG_STATUS ? status_view :
        lk.reg_addr == `PMV_REG_BUCK ? buck_code_r :
        lk.reg_addr == `PMV_REG_LDO_A ? ldo_a_code_r :
        lk.reg_addr == `PMV_REG_LDO_B ? ldo_b_code_r : 8'h00;

    // control and status registers
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            enable_r <= `PMV_ENABLE_POR;
            int_en_r <= 1'b0;
            uv_hold_r <= 1'b0;
            ot_hold_r <= 1'b0;
        end else begin
            enable_r <= enable_nxt;
            int_en_r <= int_en_nxt;
            uv_hold_r <= uv_hold_nxt;
            ot_hold_r <= ot_hold_nxt;
        end
    end

    // voltage codes are stored as written; reserved codes are the host's concern
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            buck_code_r <= `PMV_CODE_POR;
            ldo_a_code_r <= `PMV_CODE_POR;
            ldo_b_code_r <= `PMV_CODE_POR;
        end else begin
            if (wr_buck) buck_code_r <= lk.wr_data;
            if (wr_ldo_a) ldo_a_code_r <= lk.wr_data;
            if (wr_ldo_b) ldo_b_code_r <= lk.wr_data;
        end
    end

    // read answer: data and toggle change on the same edge; the link's two-flop delay lets the data settle
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rd_data_r <= 8'h00;
            rd_ack_tog_r <= 1'b0;
        end else if (rd_evt) begin
            rd_data_r <= rd_mux;
            rd_ack_tog_r <= ~rd_ack_tog_r;
        end
    end

    assign lk.rd_data = rd_data_r;
    assign lk.rd_ack_tog = rd_ack_tog_r;

    // pin outputs; the interrupt rises with the flag, not a cycle after it
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            fault_irq_n_out <= 1'b0;
            fault_irq_n_oe <= 1'b0;
            rail_enable <= 3'h0;
            seq_disable <= 1'b0;
            fault_restart <= 1'b0;
            buck_mv <= 12'h000;
            ldo_a_mv <= 12'h000;
            ldo_b_mv <= 12'h000;
        end else begin
            fault_irq_n_out <= 1'b0;
            fault_irq_n_oe <= int_en_nxt && (uv_hold_nxt || ot_hold_nxt);
            rail_enable <= enable_nxt[2:0];
            seq_disable <= enable_nxt[4];
            fault_restart <= enable_nxt[5];
            buck_mv <= buck_to_mv(buck_code_r);
            ldo_a_mv <= ldo_to_mv(ldo_a_code_r);
            ldo_b_mv <= ldo_to_mv(ldo_b_code_r);
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    a_irq_needs_fault: assert property (
        fault_irq_n_oe |-> (uv_hold_r || ot_hold_r))
        else $error("interrupt driven without a fault flag");
    a_irq_with_fault: assert property (
        (int_en_r && !wr_status && uv_live) |=> fault_irq_n_oe && uv_hold_r)
        else $error("interrupt late for an undervoltage fault");
    a_irq_masked: assert property (
        !int_en_r ##1 !int_en_r |-> !fault_irq_n_oe)
        else $error("interrupt driven while disabled");
    a_en_rise_default: assert property (
        en_rise |=> enable_r == `PMV_ENABLE_DEFAULT && rail_enable == 3'h7)
        else $error("enable edge did not load defaults");
    a_en_level_quiet: assert property (
        (in_s2_r[0] == in_s3_r[0] && !wr_evt) |=> $stable(enable_r))
        else $error("steady enable level changed the enables");
    a_buck_map_knee: assert property (
        buck_code_r == 8'h0f ##1 buck_code_r == 8'h0f |-> buck_mv == 12'h497)
        else $error("buck fine step wrong");
    a_buck_map_top: assert property (
        buck_code_r == `PMV_BUCK_MAX_CODE ##1 buck_code_r == `PMV_BUCK_MAX_CODE
        |-> buck_mv == 12'h708)
        else $error("buck coarse step wrong");
    a_ldo_a_map: assert property (
        ldo_a_code_r == 8'he8 ##1 ldo_a_code_r == 8'he8 |-> ldo_a_mv == 12'hce4)
        else $error("first regulator table wrong");
    a_ldo_b_map: assert property (
        ldo_b_code_r == 8'h45 ##1 ldo_b_code_r == 8'h45 |-> ldo_b_mv == 12'h4b0)
        else $error("second regulator table wrong");
    a_addr_unmapped: assert property (
        (rd_evt && lk.reg_addr > `PMV_REG_LDO_B) |=> rd_data_r == 8'h00)
        else $error("unmapped register read not zero");
    a_write_lands: assert property (
        wr_buck |=> buck_code_r == $past(lk.wr_data))
        else $error("buck code write lost");

    c_enable_edge: cover property (en_rise);
    c_write_buck: cover property (wr_buck);
    c_fault_irq: cover property (fault_irq_n_oe);
endmodule : pmv_top
`default_nettype wire

// ---- verif/pmv_host_model.sv ----
// serial bus host model: start, stop, byte transfers, register write and read
`timescale 1ns/100ps
`default_nettype none
module pmv_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h2c, // arbitrary value, matches the device
    parameter real HALF = 15.0 // half of the serial clock period, ns
) (
    output logic scl, // serial clock, stands high outside frames
    output logic sda_pull, // high while the host pulls data low
    input wire logic sda_line // resolved data wire level
);
    // bus idles released: the pull-up holds both lines high
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // one clock pulse: data changes only while the clock is low, sampled while high
    task automatic clk_bit(input logic pull, output logic seen);
        sda_pull = pull;
        #(HALF / 2);
        scl = 1'b1;
        #(HALF / 2);
        seen = sda_line;
        #(HALF / 2);
        scl = 1'b0;
        #(HALF / 2);
    endtask : clk_bit

    // data edge while the clock is high: (0,1) is a start or repeat, (1,0) a stop
    task automatic cond(input logic first, input logic second);
        sda_pull = first;
        #(HALF / 2);
        scl = 1'b1;
        #(HALF / 2);
        sda_pull = second;
        #(HALF / 2);
        scl = ~second;
        #(HALF * 2);
    endtask : cond

    // byte to the device, msb first, then the device's acknowledge
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic seen;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(~b[i], seen);
        end
        clk_bit(1'b0, seen);
        ack = ~seen;
    endtask : put_byte

    // byte from the device; the last byte is refused so the device lets go
    task automatic get_byte(input logic last, output logic [7:0] b);
        logic seen;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b0, b[i]);
        end
        clk_bit(~last, seen);
    endtask : get_byte

    task automatic write_reg(input logic [6:0] dev, input logic [7:0] ra,
        input logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        cond(1'b0, 1'b1);
        put_byte({dev, 1'b0}, a0);
        put_byte(ra, a1);
        put_byte(d, a2);
        cond(1'b1, 1'b0);
        ok = a0 & a1 & a2;
    endtask : write_reg

    // register address is written first, then a repeated start turns the bus round
    task automatic read_reg(input logic [7:0] ra, output logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        cond(1'b0, 1'b1);
        put_byte({DEV_ADDR, 1'b0}, a0);
        put_byte(ra, a1);
        #(HALF * 16); // the core needs a few of its clocks to snapshot the register
        cond(1'b0, 1'b1);
        put_byte({DEV_ADDR, 1'b1}, a2);
        get_byte(1'b1, d);
        cond(1'b1, 1'b0);
        ok = a0 & a1 & a2;
    endtask : read_reg
endmodule : pmv_host_model
`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking bench of the voltage code register block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam logic [6:0] DEV = 7'h2c; // arbitrary device address
    localparam logic [7:0] LDO_CODE [51] = '{8'h00, 8'h0b, 8'h14, 8'h1d, 8'h25, 8'h2e,
        8'h37, 8'h3e, 8'h45, 8'h4c, 8'h52, 8'h57, 8'h5c, 8'h61, 8'h65, 8'h69, 8'h6d, 8'h72,
        8'h79, 8'h7f, 8'h85, 8'h8b, 8'h91, 8'h96, 8'h9a, 8'h9f, 8'ha4, 8'ha8, 8'hac, 8'hb0,
        8'hb4, 8'hb7, 8'hba, 8'hbd, 8'hc1, 8'hc4, 8'hc7, 8'hc9, 8'hcc, 8'hce, 8'hd1, 8'hd3,
        8'hd6, 8'hd8, 8'hda, 8'hdc, 8'hde, 8'he1, 8'he3, 8'he6, 8'he8};
    logic clock = 1'b0;
    logic reset;
    logic enable_pin = 1'b0;
    logic input_undervoltage_flag = 1'b0;
    logic thermal_shutdown_flag = 1'b0;
    logic [2:0] rail_valid = 3'h0;
    logic scl, sda_pull, sda_out, sda_oe, fault_irq_n_out, fault_irq_n_oe;
    logic seq_disable, fault_restart;
    logic [2:0] rail_enable;
    logic [11:0] buck_mv, ldo_a_mv, ldo_b_mv;
    int error_cnt = 0;
    int n_compared = 0;
    // open-drain data wire: low if either side pulls, else the pull-up wins
    wire sda_line = ~(sda_pull | (sda_oe & ~sda_out));

    always #20 clock = ~clock;

    pmv_top #(.DEV_ADDR(DEV)) pmv_top_i (.clock(clock), .reset(reset), .scl(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .enable_pin(enable_pin),
        .input_undervoltage_flag(input_undervoltage_flag),
        .thermal_shutdown_flag(thermal_shutdown_flag), .rail_valid(rail_valid),
        .fault_irq_n_out(fault_irq_n_out), .fault_irq_n_oe(fault_irq_n_oe),
        .rail_enable(rail_enable), .seq_disable(seq_disable), .fault_restart(fault_restart),
        .buck_mv(buck_mv), .ldo_a_mv(ldo_a_mv), .ldo_b_mv(ldo_b_mv));
    pmv_host_model #(.DEV_ADDR(DEV)) pmv_host_model_i (.scl(scl), .sda_pull(sda_pull),
        .sda_line(sda_line));

    task automatic stop_test();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_byte

    task automatic chk_mv(input string what, input logic [11:0] exp, input logic [11:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk_mv

    // sample a little after the edge so that its updates have landed
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : settle

    // enable-side outputs packed in the enable register's own layout
    function automatic logic [7:0] outs();
        return {2'b00, fault_restart, seq_disable, 1'b0, rail_enable};
    endfunction : outs

    function automatic logic [7:0] irq();
        return {6'h00, fault_irq_n_out, fault_irq_n_oe};
    endfunction : irq

    // core applies a write four clocks after the last ack; six leaves margin
    task automatic reg_wr(input logic [7:0] ra, input logic [7:0] d);
        logic ok;
        pmv_host_model_i.write_reg(DEV, ra, d, ok);
        chk_byte("write ack", 8'h01, {7'h00, ok});
        settle(6);
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] ra, input logic [7:0] exp);
        logic ok;
        logic [7:0] d;
        pmv_host_model_i.read_reg(ra, d, ok);
        chk_byte("read ack", 8'h01, {7'h00, ok});
        chk_byte("read data", exp, d);
    endtask : reg_rd

    task automatic t_reset();
        chk_byte("enable outputs", 8'h20, outs());
        chk_mv("buck_mv", 12'h320, buck_mv);
        chk_mv("ldo_a_mv", 12'h320, ldo_a_mv);
        reg_rd(8'h00, 8'h20);
        reg_rd(8'h01, 8'h00);
    endtask : t_reset

    // every buck code plus the first reserved one, each read back
    task automatic t_buck();
        logic [11:0] mv;
        for (int c = 0; c <= 29; c++) begin
            mv = (c < 16) ? 12'h320 + 12'h019 * 12'(c) : 12'h4b0 + 12'h032 * 12'(c - 16);
            if (c > 28) mv = 12'h000;
            reg_wr(8'h02, 8'(c));
            chk_mv("buck_mv", mv, buck_mv);
            reg_rd(8'h02, 8'(c));
        end
    endtask : t_buck

    // both regulators walk the table in opposite directions
    task automatic t_ldo();
        for (int i = 0; i < 51; i++) begin
            reg_wr(8'h03, LDO_CODE[i]);
            reg_wr(8'h04, LDO_CODE[50 - i]);
            chk_mv("ldo_a_mv", 12'h320 + 12'h032 * 12'(i), ldo_a_mv);
            chk_mv("ldo_b_mv", 12'h320 + 12'h032 * 12'(50 - i), ldo_b_mv);
        end
        reg_rd(8'h04, 8'h00);
        reg_wr(8'h03, 8'h01);
        chk_mv("ldo_a_mv", 12'h000, ldo_a_mv);
        reg_rd(8'h03, 8'h01);
    endtask : t_ldo

    task automatic t_decode();
        reg_wr(8'hfa, 8'h12);
        chk_mv("buck_mv", 12'h514, buck_mv);
        reg_rd(8'h02, 8'h12);
        reg_wr(8'h05, 8'h55); // unmapped place
        reg_rd(8'h0d, 8'h00);
        chk_mv("buck_mv", 12'h514, buck_mv);
    endtask : t_decode

    task automatic t_foreign();
        logic ok;
        pmv_host_model_i.write_reg(7'h2d, 8'h02, 8'h05, ok);
        settle(6);
        chk_byte("foreign ack", 8'h00, {7'h00, ok});
        chk_mv("buck_mv", 12'h514, buck_mv);
        reg_rd(8'h02, 8'h12);
    endtask : t_foreign

    // a steady high level must not undo a register write; only rising edges act
    task automatic t_enable();
        @(posedge clock);
        enable_pin <= 1'b1;
        settle(4);
        chk_byte("enable outputs", 8'h27, outs());
        reg_rd(8'h00, 8'h27);
        reg_wr(8'h00, 8'h00);
        settle(20);
        chk_byte("enable outputs", 8'h00, outs());
        @(posedge clock);
        enable_pin <= 1'b0;
        settle(20);
        chk_byte("enable outputs", 8'h00, outs());
        @(posedge clock);
        enable_pin <= 1'b1;
        settle(4);
        chk_byte("enable outputs", 8'h27, outs());
        // reserved enable bits are masked; high address bits are ignored
        reg_wr(8'hf8, 8'hff);
        chk_byte("enable outputs", 8'h37, outs());
        reg_rd(8'h00, 8'h37);
    endtask : t_enable

    task automatic t_irq();
        @(posedge clock);
        rail_valid <= 3'h5;
        input_undervoltage_flag <= 1'b1;
        settle(6);
        chk_byte("irq drive", 8'h00, irq());
        reg_rd(8'h01, 8'h25);
        reg_wr(8'h01, 8'h40);
        chk_byte("irq drive", 8'h01, irq());
        // echo clear while the fault persists: the flag must stay set
        reg_wr(8'h01, 8'h60);
        reg_rd(8'h01, 8'h65);
        @(posedge clock);
        input_undervoltage_flag <= 1'b0;
        settle(6);
        reg_wr(8'h01, 8'h60); // echo clear, interrupt stays enabled
        chk_byte("irq drive", 8'h00, irq());
        @(posedge clock);
        rail_valid <= 3'h2;
        settle(6);
        chk_byte("irq drive", 8'h00, irq());
        @(posedge clock);
        thermal_shutdown_flag <= 1'b1;
        settle(1);
        chk_byte("irq drive", 8'h00, irq());
        settle(3);
        chk_byte("irq drive", 8'h01, irq());
        reg_rd(8'h01, 8'h52);
        @(posedge clock);
        thermal_shutdown_flag <= 1'b0;
        settle(6);
        reg_wr(8'h01, 8'h10); // clear and disable
        chk_byte("irq drive", 8'h00, irq());
    endtask : t_irq

    // watchdog: the whole sequence needs well under half a millisecond
    initial begin
        #2000000;
        error_cnt++;
        stop_test();
    end

    initial begin
        reset <= 1'b1; // a real x-to-one edge, so the async reset branches run
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        settle(4);
        t_reset();
        t_buck();
        t_ldo();
        t_decode();
        t_foreign();
        t_enable();
        t_irq();
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
